// ### src/spoc_pkg.sv
// Package for the SPI optional-feature control block: offsets, fields,
// reset values and timing counts.
// Assumes a 50 MHz module clock and a byte-wide register port.
package spoc_pkg;
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam int SYNC_W = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_FC = 4'h2;
  localparam logic [ADDR_W-1:0] OFS_C1 = 4'h3;
  localparam logic [ADDR_W-1:0] OFS_MATCH_HI = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_DATA_HI = 4'h5;
  localparam logic [ADDR_W-1:0] OFS_DATA_LO = 4'h6;
  localparam logic [ADDR_W-1:0] OFS_MATCH_LO = 4'h7;
  localparam logic [ADDR_W-1:0] OFS_IRQ_STAT = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 4'h9;

  // Feature control fields
  localparam int FC_MATCH_IE = 7;
  localparam int FC_WIDTH = 6;
  localparam int FC_TXDMA = 5;
  localparam int FC_MODF_EN = 4;
  localparam int FC_BIDIR_OE = 3;
  localparam int FC_RXDMA = 2;
  localparam int FC_STOP_WAIT = 1;
  localparam int FC_PIN_CTL0 = 0;

  // Control register one fields
  localparam int C1_SE = 6;
  localparam int C1_MASTER = 4;
  localparam int C1_SELECT_OUTPUT_ENABLE = 1;

  // Status fields
  localparam int ST_RF = 7;
  localparam int ST_MATCH = 6;
  localparam int ST_TEF = 5;
  localparam int ST_MODF = 4;

  // Interrupt status and mask fields
  localparam int IRQ_MATCH = 3;
  localparam int IRQ_RF = 2;
  localparam int IRQ_TEF = 1;
  localparam int IRQ_MODF = 0;

  localparam logic [7:0] RST_FC = 8'h00;
  localparam logic [7:0] RST_C1 = 8'h00;
  localparam logic [3:0] RST_IRQ = 4'h0;
  // Pin order {sclk, ss_n, mosi, miso}; select idles high
  localparam logic [SYNC_W-1:0] SYNC_RST = 4'h4;

  // Master serial clock timing
  localparam int CLK_MHZ = 50;
  localparam int SCK_HALF_NS = 80;
  localparam int SCK_HALF_CYC = (SCK_HALF_NS * CLK_MHZ) / 1000;
  localparam int DIV_W = 3;
  localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(SCK_HALF_CYC - 1);
  localparam logic [4:0] BITS_NARROW = 5'h08;
  localparam logic [4:0] BITS_WIDE = 5'h10;

  typedef enum logic [0:0] {SPOC_IDLE, SPOC_RUN} spoc_state_e;
endpackage

// ### src/spoc_sync.sv
// Two-stage synchroniser for the serial pins.
// Assumes the inputs are asynchronous to clk.
module spoc_sync import spoc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [SYNC_W-1:0] async_in,
  output logic [SYNC_W-1:0] sync_out
);
  logic [SYNC_W-1:0] meta_reg;
  logic [SYNC_W-1:0] sync_reg;

  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_bit
      always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
          meta_reg[g] <= SYNC_RST[g];
          sync_reg[g] <= SYNC_RST[g];
        end else begin
          meta_reg[g] <= async_in[g];
          sync_reg[g] <= meta_reg[g];
        end
      end
    end
  endgenerate

  assign sync_out = sync_reg;
endmodule // spoc_sync

// ### src/spoc_top.sv
// SPI with optional-feature control: register port, mode-0 shift engine,
// DMA requests, interrupt, select and data pin steering.
// Assumes pins are asynchronous; register strobes are on clk.
// Function
// - Match interrupt enable lets the match flag raise the interrupt.
// - Width select picks 8 or 16 bit shift, match and buffers.
// - Master width change aborts transfer, idles, clears receive, match and fault flags, sets transmit empty.
// - Transmit DMA request when enabled, transmit empty and enabled system.
// - Transmit DMA enable blocks transmit-empty interrupt.
// - Slave ignores mode-fault enable; select pin is an input.
// - Master without mode-fault enable releases select pin, no detection.
// - Master with mode-fault enable: fault input or select output.
// - Shared pin driver gated by bidirectional output enable.
// - Output enable zero makes shared pin input, one drives it.
// - Separate pins: bidirectional output enable has no effect.
// - Pin control zero selects single shared data pin.
// - Receive DMA request when enabled, full and system enabled.
// - Stop-in-wait freezes the engine during wait mode.
module spoc_top import spoc_pkg::*; (
  input wire logic clk,
  input wire logic rst,
  input wire logic [ADDR_W-1:0] addr,
  input wire logic [DATA_W-1:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [DATA_W-1:0] rdata,
  output logic irq,
  output logic tx_dma_req,
  output logic rx_dma_req,
  input wire logic wait_mode,
  output logic clocks_stopped,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe,
  input wire logic ss_n_i,
  output logic ss_n_o,
  output logic ss_n_oe,
  input wire logic mosi_i,
  output logic mosi_o,
  output logic mosi_oe,
  input wire logic miso_i,
  output logic miso_o,
  output logic miso_oe
);
  function automatic logic hit(input logic [ADDR_W-1:0] a,
                               input logic [ADDR_W-1:0] ofs);
    return a == ofs;
  endfunction

  logic [SYNC_W-1:0] pin_sync;
  logic sck_s, ss_s, mosi_s, miso_s;
  spoc_sync u_sync (
    .clk(clk),
    .rst(rst),
    .async_in({sclk_i, ss_n_i, mosi_i, miso_i}),
    .sync_out(pin_sync)
  );
  assign {sck_s, ss_s, mosi_s, miso_s} = pin_sync;

  spoc_state_e st_reg, st_next;
  logic [7:0] fc_reg, fc_next, c1_reg, c1_next, tx_hi_reg, tx_hi_next;
  logic [15:0] tx_buf_reg, tx_buf_next, rx_buf_reg, rx_buf_next;
  logic [15:0] match_reg, match_next, sh_reg, sh_next;
  logic rf_reg, rf_next, tef_reg, tef_next, mf_reg, mf_next;
  logic modf_reg, modf_next, din_reg, din_next;
  logic sck_reg, sck_next, sck_prev_reg, sck_prev_next;
  logic [3:0] irq_stat_reg, irq_stat_next, irq_mask_reg, irq_mask_next;
  logic [4:0] bit_reg, bit_next;
  logic [DIV_W-1:0] div_reg, div_next;
  logic [DATA_W-1:0] rdata_next;
  logic master, se, wide, pcz, frozen, abort, rise, fall, done, din, dout;
  logic [4:0] nbits;
  logic [15:0] word, match_cmp;

  always_comb begin
    st_next = st_reg;
    fc_next = fc_reg;
    c1_next = c1_reg;
    tx_hi_next = tx_hi_reg;
    tx_buf_next = tx_buf_reg;
    rx_buf_next = rx_buf_reg;
    match_next = match_reg;
    sh_next = sh_reg;
    rf_next = rf_reg;
    tef_next = tef_reg;
    mf_next = mf_reg;
    modf_next = modf_reg;
    din_next = din_reg;
    sck_next = sck_reg;
    sck_prev_next = sck_s;
    irq_stat_next = irq_stat_reg;
    irq_mask_next = irq_mask_reg;
    bit_next = bit_reg;
    div_next = div_reg;
    rdata_next = 8'h00;
    master = c1_reg[C1_MASTER];
    se = c1_reg[C1_SE];
    wide = fc_reg[FC_WIDTH];
    pcz = fc_reg[FC_PIN_CTL0];
    nbits = wide ? BITS_WIDE : BITS_NARROW;
    match_cmp = wide ? match_reg : {8'h00, match_reg[7:0]};
    din = master ? (pcz ? mosi_s : miso_s) : (pcz ? miso_s : mosi_s);
    frozen = fc_reg[FC_STOP_WAIT] & wait_mode;
    word = {sh_reg[14:0], din_reg};
    if (!wide) begin
      word = {8'h00, word[7:0]};
    end
    abort = 1'b0;
    rise = 1'b0;
    fall = 1'b0;
    done = 1'b0;
    // Reads and clears first, so hardware sets below win
    if (rd_en) begin
      if (hit(addr, OFS_STATUS)) begin
        rdata_next = {rf_reg, mf_reg, tef_reg, modf_reg, 4'h0};
      end else if (hit(addr, OFS_FC)) begin
        rdata_next = fc_reg;
      end else if (hit(addr, OFS_C1)) begin
        rdata_next = c1_reg;
      end else if (hit(addr, OFS_MATCH_HI)) begin
        rdata_next = wide ? match_reg[15:8] : 8'h00;
      end else if (hit(addr, OFS_DATA_HI)) begin
        rdata_next = wide ? rx_buf_reg[15:8] : 8'h00;
      end else if (hit(addr, OFS_DATA_LO)) begin
        rdata_next = rx_buf_reg[7:0];
        rf_next = 1'b0;
      end else if (hit(addr, OFS_MATCH_LO)) begin
        rdata_next = match_reg[7:0];
      end else if (hit(addr, OFS_IRQ_STAT)) begin
        rdata_next = {4'h0, irq_stat_reg};
      end else if (hit(addr, OFS_IRQ_MASK)) begin
        rdata_next = {4'h0, irq_mask_reg};
      end
    end
    if (wr_en) begin
      if (hit(addr, OFS_FC)) begin
        fc_next = wdata;
        abort = master && (wdata[FC_WIDTH] != fc_reg[FC_WIDTH]);
      end else if (hit(addr, OFS_C1)) begin
        c1_next = wdata;
        abort = se && !wdata[C1_SE];
      end else if (hit(addr, OFS_STATUS)) begin
        mf_next = mf_reg & ~wdata[ST_MATCH];
        modf_next = modf_reg & ~wdata[ST_MODF];
      end else if (hit(addr, OFS_MATCH_HI)) begin
        match_next[15:8] = wdata;
      end else if (hit(addr, OFS_MATCH_LO)) begin
        match_next[7:0] = wdata;
      end else if (hit(addr, OFS_DATA_HI)) begin
        tx_hi_next = wdata;
      end else if (hit(addr, OFS_IRQ_STAT)) begin
        irq_stat_next = irq_stat_reg & ~wdata[3:0];
      end else if (hit(addr, OFS_IRQ_MASK)) begin
        irq_mask_next = wdata[3:0];
      end
    end
    // fault detect only with mode-fault enable, select input
    if (se && master && fc_reg[FC_MODF_EN] && !c1_reg[C1_SELECT_OUTPUT_ENABLE] && !ss_s) begin
      modf_next = 1'b1;
      irq_stat_next[IRQ_MODF] = 1'b1;
      c1_next[C1_MASTER] = 1'b0;
      abort = 1'b1;
    end
    if (abort) begin
      st_next = SPOC_IDLE;
      rf_next = 1'b0;
      mf_next = 1'b0;
      modf_next = modf_next & ~(wr_en & hit(addr, OFS_FC));
      tef_next = 1'b1;
      sck_next = 1'b0;
    end else if (!frozen) begin
      unique case (st_reg)
        SPOC_IDLE: begin
          // slave starts on select input low with serial clock low, not on transmit data
          if (se && (master ? !tef_reg : (!ss_s && !sck_s))) begin
            st_next = SPOC_RUN;
            sh_next = tx_buf_reg;
            bit_next = 5'h00;
            div_next = '0;
            sck_next = 1'b0;
            tef_next = 1'b1;
            irq_stat_next[IRQ_TEF] = 1'b1;
          end
        end
        SPOC_RUN: begin
          if (master) begin
            if (div_reg == DIV_LAST) begin
              div_next = '0;
              sck_next = ~sck_reg;
              rise = !sck_reg;
              fall = sck_reg;
            end else begin
              div_next = DIV_W'(div_reg + 1'b1);
            end
          end else begin
            rise = sck_s & ~sck_prev_reg;
            fall = ~sck_s & sck_prev_reg;
            if (ss_s) begin
              st_next = SPOC_IDLE;
            end
          end
          if (rise) begin
            din_next = din;
            bit_next = 5'(bit_reg + 1'b1);
          end
          if (fall) begin
            sh_next = {sh_reg[14:0], din_reg};
            if (bit_reg == nbits) begin
              done = 1'b1;
              st_next = SPOC_IDLE;
            end
          end
        end
      endcase
    end
    if (done) begin
      rx_buf_next = word;
      rf_next = 1'b1;
      irq_stat_next[IRQ_RF] = 1'b1;
      if (word == match_cmp) begin
        mf_next = 1'b1;
        irq_stat_next[IRQ_MATCH] = 1'b1;
      end
    end
    // Buffer write last: a refill in the start cycle is not lost
    if (wr_en && hit(addr, OFS_DATA_LO)) begin
      tx_buf_next = wide ? {tx_hi_reg, wdata} : {8'h00, wdata};
      tef_next = 1'b0;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_reg <= SPOC_IDLE;
      fc_reg <= RST_FC;
      c1_reg <= RST_C1;
      tx_hi_reg <= 8'h00;
      tx_buf_reg <= 16'h0000;
      rx_buf_reg <= 16'h0000;
      match_reg <= 16'h0000;
      sh_reg <= 16'h0000;
      rf_reg <= 1'b0;
      tef_reg <= 1'b1;
      mf_reg <= 1'b0;
      modf_reg <= 1'b0;
      din_reg <= 1'b0;
      sck_reg <= 1'b0;
      sck_prev_reg <= 1'b0;
      irq_stat_reg <= RST_IRQ;
      irq_mask_reg <= RST_IRQ;
      bit_reg <= 5'h00;
      div_reg <= '0;
      rdata <= 8'h00;
    end else begin
      st_reg <= st_next;
      fc_reg <= fc_next;
      c1_reg <= c1_next;
      tx_hi_reg <= tx_hi_next;
      tx_buf_reg <= tx_buf_next;
      rx_buf_reg <= rx_buf_next;
      match_reg <= match_next;
      sh_reg <= sh_next;
      rf_reg <= rf_next;
      tef_reg <= tef_next;
      mf_reg <= mf_next;
      modf_reg <= modf_next;
      din_reg <= din_next;
      sck_reg <= sck_next;
      sck_prev_reg <= sck_prev_next;
      irq_stat_reg <= irq_stat_next;
      irq_mask_reg <= irq_mask_next;
      bit_reg <= bit_next;
      div_reg <= div_next;
      rdata <= rdata_next;
    end
  end

  // Pin, request and interrupt outputs, one cycle behind the state
  logic irq_next, txd_next, rxd_next, run;
  logic sck_o_next, sck_oe_next, ss_o_next, ss_oe_next;
  logic mosi_oe_next, miso_oe_next;
  logic [3:0] irq_gate;
  always_comb begin
    run = st_reg == SPOC_RUN;
    dout = wide ? sh_reg[15] : sh_reg[7];
    irq_gate = {fc_reg[FC_MATCH_IE], ~fc_reg[FC_RXDMA],
                ~fc_reg[FC_TXDMA], 1'b1};
    irq_next = |(irq_stat_reg & irq_mask_reg & irq_gate);
    txd_next = fc_reg[FC_TXDMA] & tef_reg & se;
    rxd_next = fc_reg[FC_RXDMA] & rf_reg & se;
    sck_o_next = master & sck_reg;
    sck_oe_next = se & master;
    // select output only with fault enable and output enable
    ss_o_next = !run;
    ss_oe_next = se & master & fc_reg[FC_MODF_EN] & c1_reg[C1_SELECT_OUTPUT_ENABLE];
    mosi_oe_next = se & master & (!pcz | fc_reg[FC_BIDIR_OE]);
    miso_oe_next = se & !master & !ss_s & (!pcz | fc_reg[FC_BIDIR_OE]);
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      irq <= 1'b0;
      tx_dma_req <= 1'b0;
      rx_dma_req <= 1'b0;
      clocks_stopped <= 1'b0;
      sclk_o <= 1'b0;
      sclk_oe <= 1'b0;
      ss_n_o <= 1'b1;
      ss_n_oe <= 1'b0;
      mosi_o <= 1'b0;
      mosi_oe <= 1'b0;
      miso_o <= 1'b0;
      miso_oe <= 1'b0;
    end else begin
      irq <= irq_next;
      tx_dma_req <= txd_next;
      rx_dma_req <= rxd_next;
      clocks_stopped <= frozen;
      sclk_o <= sck_o_next;
      sclk_oe <= sck_oe_next;
      ss_n_o <= ss_o_next;
      ss_n_oe <= ss_oe_next;
      mosi_o <= dout;
      mosi_oe <= mosi_oe_next;
      miso_o <= dout;
      miso_oe <= miso_oe_next;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  AST_MATCH_IRQ: assert property (
    $rose(mf_reg) && irq_mask_reg[IRQ_MATCH] && fc_reg[FC_MATCH_IE]
    && $stable(fc_reg) |=> irq) else $error("match irq missing");
  AST_NARROW: assert property (
    $rose(rf_reg) && !$past(wide) |-> rx_buf_reg[15:8] == 8'h00)
    else $error("narrow word has high bits");
  AST_WIDTH_ABORT: assert property (
    wr_en && hit(addr, OFS_FC) && master && wdata[FC_WIDTH] != wide
    |=> st_reg == SPOC_IDLE && !rf_reg && !mf_reg && !modf_reg)
    else $error("width change did not abort");
  AST_TX_DMA: assert property (
    fc_reg[FC_TXDMA] && tef_reg && se |=> tx_dma_req)
    else $error("transmit dma request missing");
  AST_TX_DMA_OFF: assert property (
    !fc_reg[FC_TXDMA] |=> !tx_dma_req) else $error("stray tx dma");
  AST_SLAVE_SS: assert property (
    !master |=> !ss_n_oe) else $error("slave drives select");
  AST_MODF_OFF: assert property (
    master && !fc_reg[FC_MODF_EN] |=> !ss_n_oe && !$rose(modf_reg))
    else $error("select pin not released");
  AST_SS_OUT: assert property (
    se && master && fc_reg[FC_MODF_EN] && c1_reg[C1_SELECT_OUTPUT_ENABLE] && run
    |=> ss_n_oe && !ss_n_o) else $error("select output not low");
  AST_BIDIR_IN: assert property (
    se && master && pcz && !fc_reg[FC_BIDIR_OE] |=> !mosi_oe)
    else $error("shared pin driven as input");
  AST_SEPARATE: assert property (
    se && master && !pcz |=> mosi_oe && !miso_oe)
    else $error("separate pins misdriven");
  AST_RX_DMA: assert property (
    fc_reg[FC_RXDMA] && rf_reg && se |=> rx_dma_req)
    else $error("receive dma request missing");
  AST_FREEZE: assert property (
    frozen && !wr_en |=> $stable(sh_reg) && $stable(bit_reg))
    else $error("engine ran in wait");
  AST_READBACK: assert property (
    wr_en && hit(addr, OFS_FC) ##1 rd_en && hit(addr, OFS_FC)
    |=> rdata == $past(wdata, 2)) else $error("control readback bad");

  COV_MASTER_DONE: cover property (master && done);
  COV_SLAVE_DONE: cover property (!master && done);
  COV_MODF: cover property ($rose(modf_reg));
  COV_MATCH: cover property ($rose(mf_reg) && wide);
endmodule // spoc_top

// ### tb/spoc_link_model.sv
// Far-side SPI peer: answers as a slave or drives frames as a master.
// Mode 0, MSB first. Assumes the bench resolves each pin from the enables.
module spoc_link_model (
  input wire logic sclk_w,
  input wire logic ss_w,
  input wire logic mosi_w,
  input wire logic miso_w,
  output logic sclk_m,
  output logic ss_m,
  output logic mosi_m,
  output logic miso_m
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] tx_word;
  logic [15:0] rx_word;
  logic [15:0] sh;
  int bits;
  logic s_act;
  logic m_act;
  logic miso_q;
  logic mosi_q;
  // Released lines show the inverse of the last bit, never a stale copy
  assign miso_m = s_act ? miso_q : ~miso_q;
  assign mosi_m = m_act ? mosi_q : ~mosi_q;
  initial begin
    tx_word = 16'h0000;
    rx_word = 16'h0000;
    bits = 8;
    s_act = 1'b0;
    m_act = 1'b0;
    miso_q = 1'b0;
    mosi_q = 1'b0;
    sclk_m = 1'b0;
    ss_m = 1'b1;
  end
  always @(negedge ss_w) begin
    if (!m_act) begin
      s_act = 1'b1;
      sh = tx_word;
      miso_q = sh[bits-1];
    end
  end
  always @(posedge ss_w) s_act = 1'b0;
  always @(posedge sclk_w) begin
    if (s_act) rx_word = {rx_word[14:0], mosi_w};
  end
  always @(negedge sclk_w) begin
    if (s_act) begin
      sh = sh << 1;
      miso_q = sh[bits-1];
    end
  end
  // Serial clock runs only inside the frame; long lead-in for sync delay
  task automatic run_master(input logic [15:0] w, input int n);
    m_act = 1'b1;
    sh = w;
    mosi_q = sh[n-1];
    #7;
    ss_m = 1'b0;
    #160;
    for (int i = 0; i < n; i++) begin
      sclk_m = 1'b1;
      rx_word = {rx_word[14:0], miso_w};
      #80;
      sclk_m = 1'b0;
      sh = sh << 1;
      mosi_q = sh[n-1];
      #80;
    end
    ss_m = 1'b1;
    m_act = 1'b0;
  endtask
endmodule // spoc_link_model

// ### tb/spoc_tb_top.sv
// Self-checking bench for the SPI feature control block.
// Assumes the link peer model and a 50 MHz clock; no random stimulus.
module spoc_tb_top import spoc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [7:0] B_SE = 8'h01 << C1_SE;
  localparam logic [7:0] B_MS = 8'h01 << C1_MASTER;
  localparam logic [7:0] B_SO = 8'h01 << C1_SELECT_OUTPUT_ENABLE;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] addr = '0;
  logic [DATA_W-1:0] wdata = '0;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic wait_mode = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic irq, tx_dma_req, rx_dma_req, clocks_stopped;
  logic sclk_o, sclk_oe, ss_n_o, ss_n_oe, mosi_o, mosi_oe, miso_o, miso_oe;
  logic sclk_m, ss_m, mosi_m, miso_m;
  logic sclk_w, ss_w, mosi_w, miso_w;
  logic [7:0] fc = 8'h00;
  logic [7:0] rv;
  int err_total = 0;
  int compares = 0;
  always #10 clk = ~clk;
  // Select pin pulled up, clock idles low via the peer
  assign sclk_w = sclk_oe ? sclk_o : sclk_m;
  assign ss_w = ss_n_oe ? ss_n_o : ss_m;
  assign mosi_w = mosi_oe ? mosi_o : mosi_m;
  assign miso_w = miso_oe ? miso_o : miso_m;
  spoc_top dut (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .irq(irq),
    .tx_dma_req(tx_dma_req), .rx_dma_req(rx_dma_req),
    .wait_mode(wait_mode), .clocks_stopped(clocks_stopped),
    .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
    .ss_n_i(ss_w), .ss_n_o(ss_n_o), .ss_n_oe(ss_n_oe),
    .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe),
    .miso_i(miso_w), .miso_o(miso_o), .miso_oe(miso_oe));
  spoc_link_model lm (.sclk_w(sclk_w), .ss_w(ss_w), .mosi_w(mosi_w),
    .miso_w(miso_w), .sclk_m(sclk_m), .ss_m(ss_m), .mosi_m(mosi_m),
    .miso_m(miso_m));
  task automatic chk(input string s, input logic [7:0] e,
                     input logic [7:0] g);
    compares++;
    if (g !== e) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", s, e, g);
    end
  endtask
  // Settle afterwards so lagging pins and the interrupt have landed
  task automatic wr(input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  task automatic rd(input logic [ADDR_W-1:0] a, output logic [7:0] d);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(posedge clk);
    d = rdata;
  endtask
  task automatic rchk(input string s, input logic [ADDR_W-1:0] a,
                      input logic [7:0] e);
    rd(a, rv);
    chk(s, e, rv);
  endtask
  task automatic fcb(input int b, input logic v);
    fc[b] = v;
    wr(OFS_FC, fc);
  endtask
  task automatic wait_rf();
    int n;
    n = 0;
    rv = 8'h00;
    while (rv[ST_RF] !== 1'b1 && n < 200) begin
      rd(OFS_STATUS, rv);
      n++;
    end
    chk("rx full", 8'h01, 8'(rv[ST_RF]));
  endtask
  task automatic wrap_up();
    $display("compares %0d err_total %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  initial begin
    #200000;
    err_total++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    rchk("fc reset", OFS_FC, 8'h00);
    wr(OFS_FC, 8'ha5);
    rchk("fc rw", OFS_FC, 8'ha5);
    wr(OFS_FC, 8'h5a);
    rchk("fc rw", OFS_FC, 8'h5a);
    wr(OFS_FC, fc);
    wr(4'hc, 8'hff);
    rchk("unmapped", 4'hc, 8'h00);
    wr(OFS_C1, B_SE);
    fcb(FC_MODF_EN, 1'b1);
    chk("ss oe slave", 8'h00, 8'(ss_n_oe));
    wr(OFS_C1, B_SE | B_MS | B_SO);
    chk("ss oe out", 8'h01, 8'(ss_n_oe));
    fcb(FC_MODF_EN, 1'b0);
    chk("ss oe gpio", 8'h00, 8'(ss_n_oe));
    fcb(FC_MODF_EN, 1'b1);
    wr(OFS_C1, B_SE | B_MS);
    chk("ss oe fault in", 8'h00, 8'(ss_n_oe));
    // Peer pulls select low: fault, master bit drops
    lm.ss_m <= 1'b0;
    repeat (4) @(posedge clk);
    lm.ss_m <= 1'b1;
    rchk("modf", OFS_STATUS, 8'h30);
    rchk("modf c1", OFS_C1, B_SE);
    wr(OFS_STATUS, 8'h10);
    wr(OFS_C1, B_SE | B_MS | B_SO);
    fcb(FC_BIDIR_OE, 1'b1);
    chk("oe separate", 8'h02, 8'({mosi_oe, miso_oe}));
    fcb(FC_PIN_CTL0, 1'b1);
    chk("shared drive", 8'h02, 8'({mosi_oe, miso_oe}));
    fcb(FC_BIDIR_OE, 1'b0);
    chk("shared input", 8'h00, 8'({mosi_oe, miso_oe}));
    fcb(FC_PIN_CTL0, 1'b0);
    // Master 8-bit word with a receive match
    wr(OFS_MATCH_LO, 8'h3c);
    lm.tx_word = 16'h003c;
    lm.bits = 8;
    wr(OFS_DATA_LO, 8'ha5);
    wait_rf();
    chk("peer rx", 8'ha5, lm.rx_word[7:0]);
    rchk("status", OFS_STATUS, 8'he0);
    rd(OFS_IRQ_STAT, rv);
    chk("irq stat", 8'h0c, rv & 8'h0c);
    wr(OFS_IRQ_MASK, 8'h08);
    chk("irq match off", 8'h00, 8'(irq));
    fcb(FC_MATCH_IE, 1'b1);
    chk("irq match on", 8'h01, 8'(irq));
    fcb(FC_MATCH_IE, 1'b0);
    wr(OFS_IRQ_MASK, 8'h04);
    chk("irq rf", 8'h01, 8'(irq));
    fcb(FC_RXDMA, 1'b1);
    chk("irq rf dma", 8'h00, 8'(irq));
    chk("rx dma", 8'h01, 8'(rx_dma_req));
    fcb(FC_RXDMA, 1'b0);
    rchk("data lo", OFS_DATA_LO, 8'h3c);
    wr(OFS_IRQ_MASK, 8'h02);
    chk("irq tef", 8'h01, 8'(irq));
    fcb(FC_TXDMA, 1'b1);
    chk("irq tef dma", 8'h00, 8'(irq));
    chk("tx dma", 8'h01, 8'(tx_dma_req));
    wr(OFS_C1, B_MS | B_SO);
    chk("tx dma off", 8'h00, 8'(tx_dma_req));
    fcb(FC_TXDMA, 1'b0);
    wr(OFS_IRQ_STAT, 8'h0f);
    wr(OFS_IRQ_MASK, 8'h08);
    wr(OFS_C1, B_SE | B_MS | B_SO);
    fcb(FC_MATCH_IE, 1'b1);
    // Master 16-bit word, match interrupt armed
    fcb(FC_WIDTH, 1'b1);
    wr(OFS_MATCH_HI, 8'hbe);
    wr(OFS_MATCH_LO, 8'hef);
    lm.tx_word = 16'hbeef;
    lm.bits = 16;
    wr(OFS_DATA_HI, 8'h12);
    wr(OFS_DATA_LO, 8'h34);
    wait_rf();
    chk("irq match 16", 8'h01, 8'(irq));
    chk("peer hi", 8'h12, lm.rx_word[15:8]);
    chk("peer lo", 8'h34, lm.rx_word[7:0]);
    rchk("status 16", OFS_STATUS, 8'he0);
    rchk("data hi", OFS_DATA_HI, 8'hbe);
    rchk("data lo", OFS_DATA_LO, 8'hef);
    wr(OFS_IRQ_MASK, 8'h00);
    fcb(FC_MATCH_IE, 1'b0);
    // Width change in mid-word, frozen for a while first
    wr(OFS_DATA_HI, 8'h55);
    wr(OFS_DATA_LO, 8'haa);
    repeat (20) @(posedge clk);
    chk("ss busy", 8'h00, 8'(ss_n_o));
    fcb(FC_STOP_WAIT, 1'b1);
    wait_mode <= 1'b1;
    repeat (3) @(posedge clk);
    chk("stopped", 8'h01, 8'(clocks_stopped));
    fcb(FC_STOP_WAIT, 1'b0);
    chk("running", 8'h00, 8'(clocks_stopped));
    wait_mode <= 1'b0;
    fcb(FC_WIDTH, 1'b0);
    chk("ss idle", 8'h01, 8'(ss_n_o));
    rchk("status abort", OFS_STATUS, 8'h20);
    // Shared pin master hears its own output, not the peer
    fcb(FC_BIDIR_OE, 1'b1);
    fcb(FC_PIN_CTL0, 1'b1);
    wr(OFS_DATA_LO, 8'hc3);
    wait_rf();
    rchk("shared rx", OFS_DATA_LO, 8'hc3);
    fcb(FC_PIN_CTL0, 1'b0);
    fcb(FC_BIDIR_OE, 1'b0);
    // Slave word driven by the peer at the link rate
    wr(OFS_C1, B_SE);
    chk("ss oe slave", 8'h00, 8'(ss_n_oe));
    wr(OFS_DATA_LO, 8'h96);
    lm.bits = 8;
    lm.run_master(16'h0069, 8);
    wait_rf();
    rchk("slave rx", OFS_DATA_LO, 8'h69);
    chk("slave tx", 8'h96, lm.rx_word[7:0]);
    // Reset after the slave word clears the control fields again
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rchk("fc reset 2", OFS_FC, 8'h00);
    wrap_up();
  end
endmodule // spoc_tb_top
